/* verilog/diag_stream_pkg.sv */
// Constants, register map and carrier types of the diagnostic status stream.
package diag_stream_pkg;

  // Channel plan and record layout.
  localparam int CHANNELS = 50;
  localparam logic [5:0] LAST_CHANNEL = 6'h31;
  localparam int REC_BYTES = 7;
  localparam logic [5:0] LOG_LAST_POS = 6'h33;
  localparam logic [4:0] REC_LAST_POS = 5'h1A;

  // Timestamp tick and wrap.
  localparam int TICK_US = 100;
  localparam int CLK_MHZ = 200;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam logic [11:0] STAMP_LAST = 12'hCE5;
  localparam logic [11:0] STAMP_RESET = 12'h000;

  // Characters and the network wildcard.
  localparam logic [7:0] CHAR_IDLE_LOG = 8'h2E;
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [7:0] CHAR_A_LESS_10 = 8'h37;
  localparam logic [7:0] CHAR_GT = 8'h3E;
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam logic [7:0] NETWORK_ANY = 8'hFF;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_NETWORK = 8'h04;
  localparam logic [7:0] ADDR_KEY = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_HOST_RATE = 8'h10;

  // Control and status register fields.
  localparam int CTRL_LOG_BIT = 0;
  localparam int CTRL_INSTRUMENTATION_STREAM_BIT = 1;
  localparam int CTRL_BASE_BIT = 2;
  localparam int CTRL_CARRIER_UP_BIT = 3;
  localparam int STATUS_CARRIER_BIT = 16;

  // Reset values.
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [15:0] NETWORK_RESET = 16'hFFFF;
  localparam logic [15:0] KEY_RESET = 16'h0000;
  localparam logic [31:0] HOST_RATE_BPS = 32'h0000_2580;

  // Per-dwell events, in the bit order of status byte 6.
  typedef struct packed {
    logic channel_busy;
    logic parser_error;
    logic valid_packet;
    logic data_received_flag;
    logic registration_sent_flag;
    logic registration_received_flag;
    logic ack_received_flag;
    logic data_sent_flag;
  } radio_events_s;

  // Levels sampled at the end of each dwell.
  typedef struct packed {
    logic [5:0] channel;
    logic [7:0] last_packet_strength;
    logic [7:0] idle_channel_strength;
    logic [7:0] range_delay;
    logic inbound_flow_off;
    logic outbound_flow_off;
    logic host_hold;
  } radio_levels_s;

  typedef enum logic [1:0] {
    EMIT_IDLE = 2'b00,
    EMIT_LOG = 2'b01,
    EMIT_REC = 2'b10
  } emit_state_e;

endpackage

/* verilog/radio_diag_stream.sv */
// Diagnostic status streamer with channel activity log and records.
//
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module radio_diag_stream #(
  parameter int TICK_CYCLES = diag_stream_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dwell_end,
  input wire diag_stream_pkg::radio_events_s events,
  input wire diag_stream_pkg::radio_levels_s levels,
  input wire logic remotes_registered,
  input wire logic registered_with_base,
  input wire logic [7:0] heard_system_network_id,
  input wire logic [7:0] heard_parent_network_id,
  input wire logic [15:0] heard_key,
  input wire logic sleep_request_n,
  output logic [7:0] char_data,
  output logic char_valid,
  input wire logic char_ready,
  output logic link_carrier_indicator,
  output logic [31:0] host_rate
);

  // Log char is '.' or '0' plus weights; record byte is weights or 0x30.
  function automatic logic [7:0] activity_char(input logic [2:0] act,
                                               input logic idle_zero);
    if (act == 3'h0) begin
      activity_char = idle_zero ? diag_stream_pkg::CHAR_ZERO :
                                  diag_stream_pkg::CHAR_IDLE_LOG;
    end else begin
      activity_char = idle_zero ? {5'h00, act} :
                                  diag_stream_pkg::CHAR_ZERO + {5'h00, act};
    end
  endfunction
  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    if (nib < 4'hA) begin
      hex_char = diag_stream_pkg::CHAR_ZERO + {4'h0, nib};
    end else begin
      hex_char = diag_stream_pkg::CHAR_A_LESS_10 + {4'h0, nib};
    end
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] din,
                                        input logic [3:0] sel);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        merge[b*8 +: 8] = din[b*8 +: 8];
      end
    end
  endfunction
  logic [3:0] control;
  logic [15:0] network_ids;
  logic [15:0] key;
  logic [14:0] tick_cnt;
  logic [11:0] stamp;
  diag_stream_pkg::radio_events_s dwell_flags;
  diag_stream_pkg::radio_events_s dwell_all;
  logic [2:0] dwell_act;
  logic [2:0] act_map [diag_stream_pkg::CHANNELS];
  logic [5:0] dwell_count;
  logic log_pending;
  logic rec_pending;
  logic [7:0] rec_byte [diag_stream_pkg::REC_BYTES];
  logic [11:0] rec_stamp;
  diag_stream_pkg::emit_state_e state;
  logic [5:0] pos;
  logic advance;
  logic start_log;
  logic start_rec;
  logic capture;
  logic clear_entry;
  logic [7:0] next_char;
  logic [4:0] rel;
  logic [2:0] byte_sel;
  logic [1:0] digit;
  logic id_match;
  logic wb_req;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Register writes and single-cycle acknowledge.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      control <= diag_stream_pkg::CTRL_RESET;
      network_ids <= diag_stream_pkg::NETWORK_RESET;
      key <= diag_stream_pkg::KEY_RESET;
      host_rate <= diag_stream_pkg::HOST_RATE_BPS;
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i) begin
        unique case (wb_adr_i)
          diag_stream_pkg::ADDR_CONTROL: begin
            control <= 4'(merge({28'h0, control}, wb_dat_i, wb_sel_i));
          end
          diag_stream_pkg::ADDR_NETWORK: begin
            network_ids <= 16'(merge({16'h0, network_ids}, wb_dat_i,
                                     wb_sel_i));
          end
          diag_stream_pkg::ADDR_KEY: begin
            key <= 16'(merge({16'h0, key}, wb_dat_i, wb_sel_i));
          end
          diag_stream_pkg::ADDR_HOST_RATE: begin
            host_rate <= merge(host_rate, wb_dat_i, wb_sel_i);
          end
          default: begin
          end
        endcase
      end
    end
  end
  // Register reads; unmapped addresses read zero.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        diag_stream_pkg::ADDR_CONTROL: wb_dat_o <= {28'h0, control};
        diag_stream_pkg::ADDR_NETWORK: wb_dat_o <= {16'h0, network_ids};
        diag_stream_pkg::ADDR_KEY: wb_dat_o <= {16'h0, key};
        diag_stream_pkg::ADDR_STATUS: begin
          wb_dat_o <= {15'h0, link_carrier_indicator, 4'h0, stamp};
        end
        diag_stream_pkg::ADDR_HOST_RATE: wb_dat_o <= host_rate;
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
  // Timestamp in 100 us ticks, wrapping after its last count.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tick_cnt <= 15'h0000;
      stamp <= diag_stream_pkg::STAMP_RESET;
    end else if (tick_cnt == 15'(TICK_CYCLES - 1)) begin
      tick_cnt <= 15'h0000;
      if (stamp == diag_stream_pkg::STAMP_LAST) begin
        stamp <= diag_stream_pkg::STAMP_RESET;
      end else begin
        stamp <= stamp + 12'h001;
      end
    end else begin
      tick_cnt <= tick_cnt + 15'h0001;
    end
  end
  // Remote carrier qualification and base carrier policy.
  assign id_match = heard_system_network_id == network_ids[7:0] &&
                    (heard_parent_network_id == network_ids[15:8] ||
                     network_ids[15:8] == diag_stream_pkg::NETWORK_ANY) &&
                    heard_key == key;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      link_carrier_indicator <= 1'b0;
    end else if (control[diag_stream_pkg::CTRL_BASE_BIT]) begin
      link_carrier_indicator <=
        control[diag_stream_pkg::CTRL_CARRIER_UP_BIT] ||
        remotes_registered;
    end else begin
      link_carrier_indicator <= registered_with_base && id_match;
    end
  end
  // Dwell flags collect events; an event at the dwell end is kept.
  assign dwell_all = dwell_flags | events;
  assign dwell_act = {dwell_all.registration_received_flag,
                      dwell_all.ack_received_flag,
                      dwell_all.data_sent_flag};
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dwell_flags <= '0;
    end else if (dwell_end) begin
      dwell_flags <= '0;
    end else begin
      dwell_flags <= dwell_all;
    end
  end
  // Activity map indexed by channel, ascending in frequency.
  assign clear_entry = advance && state == diag_stream_pkg::EMIT_LOG &&
                       pos < 6'(diag_stream_pkg::CHANNELS);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < diag_stream_pkg::CHANNELS; i++) begin
        act_map[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < diag_stream_pkg::CHANNELS; i++) begin
        if (dwell_end && levels.channel == 6'(i)) begin
          if (clear_entry && pos == 6'(i)) begin
            act_map[i] <= dwell_act;
          end else begin
            act_map[i] <= act_map[i] | dwell_act;
          end
        end else if (clear_entry && pos == 6'(i)) begin
          act_map[i] <= 3'h0;
        end
      end
    end
  end
  // A log line is due after each full pass of channel dwells.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dwell_count <= 6'h00;
      log_pending <= 1'b0;
    end else begin
      if (dwell_end) begin
        if (dwell_count == diag_stream_pkg::LAST_CHANNEL) begin
          dwell_count <= 6'h00;
        end else begin
          dwell_count <= dwell_count + 6'h01;
        end
      end
      if (dwell_end && dwell_count == diag_stream_pkg::LAST_CHANNEL &&
          control[diag_stream_pkg::CTRL_LOG_BIT]) begin
        log_pending <= 1'b1;
      end else if (start_log ||
                   !control[diag_stream_pkg::CTRL_LOG_BIT]) begin
        log_pending <= 1'b0;
      end
    end
  end
  // One record per dwell while the stream is on and none is in flight.
  // A dwell end in the cycle a record starts is dropped, so the snapshot
  // being sent is never overwritten and never sent twice.
  assign capture = dwell_end && control[diag_stream_pkg::CTRL_INSTRUMENTATION_STREAM_BIT] &&
                   state != diag_stream_pkg::EMIT_REC &&
                   !start_rec;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rec_pending <= 1'b0;
    end else if (capture) begin
      rec_pending <= 1'b1;
    end else if (start_rec || !control[diag_stream_pkg::CTRL_INSTRUMENTATION_STREAM_BIT]) begin
      rec_pending <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rec_stamp <= diag_stream_pkg::STAMP_RESET;
      for (int i = 0; i < diag_stream_pkg::REC_BYTES; i++) begin
        rec_byte[i] <= 8'h00;
      end
    end else if (capture) begin
      rec_stamp <= stamp;
      rec_byte[0] <= {2'h0, levels.channel};
      rec_byte[1] <= activity_char(dwell_act, 1'b1);
      rec_byte[2] <= levels.last_packet_strength;
      rec_byte[3] <= levels.idle_channel_strength;
      rec_byte[4] <= levels.range_delay;
      rec_byte[5] <= {4'h0, levels.inbound_flow_off,
                      levels.outbound_flow_off, levels.host_hold,
                      link_carrier_indicator};
      rec_byte[6] <= dwell_all;
    end
  end
  // Character selection for the current position.
  assign rel = pos[4:0] - 5'h04;
  assign byte_sel = 3'(rel / 5'h03);
  assign digit = 2'(rel % 5'h03);
  always_comb begin
    next_char = diag_stream_pkg::CHAR_LF;
    if (state == diag_stream_pkg::EMIT_LOG) begin
      if (pos < 6'(diag_stream_pkg::CHANNELS)) begin
        next_char = activity_char(act_map[pos], 1'b0);
      end else if (pos == diag_stream_pkg::LOG_LAST_POS - 6'h01) begin
        next_char = diag_stream_pkg::CHAR_CR;
      end
    end else begin
      unique case (pos[4:0])
        5'h00: next_char = hex_char(rec_stamp[11:8]);
        5'h01: next_char = hex_char(rec_stamp[7:4]);
        5'h02: next_char = hex_char(rec_stamp[3:0]);
        5'h03: next_char = diag_stream_pkg::CHAR_GT;
        diag_stream_pkg::REC_LAST_POS - 5'h01: begin
          next_char = diag_stream_pkg::CHAR_CR;
        end
        diag_stream_pkg::REC_LAST_POS: next_char = diag_stream_pkg::CHAR_LF;
        default: begin
          if (digit == 2'h0) begin
            next_char = diag_stream_pkg::CHAR_SPACE;
          end else if (digit == 2'h1) begin
            next_char = hex_char(rec_byte[byte_sel][7:4]);
          end else begin
            next_char = hex_char(rec_byte[byte_sel][3:0]);
          end
        end
      endcase
    end
  end
  // Output stream; a new line starts only while the host lets the radio wake.
  assign advance = !char_valid || char_ready;
  assign start_rec = advance && state == diag_stream_pkg::EMIT_IDLE &&
                     sleep_request_n && rec_pending;
  assign start_log = advance && state == diag_stream_pkg::EMIT_IDLE &&
                     sleep_request_n && !rec_pending && log_pending;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= diag_stream_pkg::EMIT_IDLE;
      pos <= 6'h00;
      char_valid <= 1'b0;
      char_data <= 8'h00;
    end else if (advance) begin
      unique case (state)
        diag_stream_pkg::EMIT_IDLE: begin
          char_valid <= 1'b0;
          pos <= 6'h00;
          if (start_rec) begin
            state <= diag_stream_pkg::EMIT_REC;
          end else if (start_log) begin
            state <= diag_stream_pkg::EMIT_LOG;
          end
        end
        diag_stream_pkg::EMIT_LOG: begin
          char_valid <= 1'b1;
          char_data <= next_char;
          pos <= pos + 6'h01;
          if (pos == diag_stream_pkg::LOG_LAST_POS) begin
            state <= diag_stream_pkg::EMIT_IDLE;
          end
        end
        diag_stream_pkg::EMIT_REC: begin
          char_valid <= 1'b1;
          char_data <= next_char;
          pos <= pos + 6'h01;
          if (pos[4:0] == diag_stream_pkg::REC_LAST_POS) begin
            state <= diag_stream_pkg::EMIT_IDLE;
          end
        end
        default: begin
          state <= diag_stream_pkg::EMIT_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* verif/host_terminal.sv */
// Host terminal model that sinks the diagnostic character stream.
`timescale 1ns/1ps
`default_nettype none
module host_terminal (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic [7:0] char_data,
  input wire logic char_valid,
  output logic char_ready,
  output logic sleep_request_n
);
  logic [1:0] pace = 2'h0;
  logic [7:0] got[$];
  // The sleep request stays negated so the radio keeps responding.
  assign sleep_request_n = 1'b1;
  // Receive permit; a slow host grants it one cycle in four.
  assign char_ready = !rst && (!slow || pace == 2'h3);
  always @(posedge ref_clk) begin
    pace <= rst ? 2'h0 : pace + 2'h1;
    if (!rst && char_valid && char_ready) begin
      got.push_back(char_data);
    end
  end
endmodule
`default_nettype wire

/* verif/radio_diag_stream_checker.sv */
// Concurrent checks on the diagnostic streamer ports.
`timescale 1ns/1ps
`default_nettype none
module radio_diag_stream_checker #(
  parameter int TICK_CYCLES = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] char_data,
  input wire logic char_valid,
  input wire logic char_ready,
  input wire logic remotes_registered,
  input wire logic link_carrier_indicator,
  input wire logic [31:0] host_rate
);
  logic take;
  logic acc;
  logic mapped;
  logic base_q;
  logic up_q;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign acc = char_valid && char_ready;
  assign mapped = wb_adr_i inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  // Shadow of the base mode and power-up carrier control bits.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      base_q <= 1'b0;
      up_q <= 1'b0;
    end else if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00) begin
      base_q <= wb_dat_i[2];
      up_q <= wb_dat_i[3];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_ack_answer: assert property (take |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  a_unmapped_zero: assert property (take && !wb_we_i && !mapped |=>
    wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_rate_held: assert property (
    !(take && wb_we_i && wb_adr_i == 8'h10) |=> $stable(host_rate))
    else $error("host rate moved");
  a_char_hold: assert property (char_valid && !char_ready |=>
    char_valid && $stable(char_data)) else $error("char not held");
  a_char_legal: assert property (char_valid |-> char_data inside
    {8'h0A, 8'h0D, 8'h20, 8'h2E, [8'h30:8'h39], 8'h3E, [8'h41:8'h46]})
    else $error("illegal stream character");
  a_crlf_pair: assert property (acc && char_data == 8'h0D |=>
    char_valid && char_data == 8'h0A) else $error("CR not followed by LF");
  a_line_gap: assert property (acc && char_data == 8'h0A |=>
    !char_valid) else $error("no idle cycle after line");
  a_base_carrier: assert property (
    base_q && (up_q || remotes_registered) |=> link_carrier_indicator)
    else $error("base carrier low");
  a_base_idle: assert property (
    base_q && !up_q && !remotes_registered |=> !link_carrier_indicator)
    else $error("base carrier high");
  c_record: cover property (acc && char_data == 8'h3E);
  c_line_end: cover property (acc && char_data == 8'h0A);
  c_carrier: cover property ($rose(link_carrier_indicator));
endmodule
bind radio_diag_stream radio_diag_stream_checker #(
  .TICK_CYCLES(TICK_CYCLES)
) chk_u (
  .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .char_data(char_data), .char_valid(char_valid), .char_ready(char_ready),
  .remotes_registered(remotes_registered),
  .link_carrier_indicator(link_carrier_indicator), .host_rate(host_rate)
);
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the diagnostic status streamer.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk;
  logic rst;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  logic dwell_end;
  diag_stream_pkg::radio_events_s events;
  diag_stream_pkg::radio_levels_s levels;
  logic rem_reg;
  logic reg_base;
  logic [7:0] h_sys;
  logic [7:0] h_par;
  logic [15:0] h_key;
  logic sleep_n;
  logic [7:0] char_data;
  logic char_valid;
  logic char_ready;
  logic carrier;
  logic [31:0] host_rate;
  logic slow;
  logic [31:0] q;
  logic [11:0] s0;
  logic [7:0] addrs[5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
  logic [31:0] rvals[5] = '{32'h0, 32'hFFFF, 32'h0, 32'h2580, 32'h0};
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  radio_diag_stream #(.TICK_CYCLES(8)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .dwell_end(dwell_end),
    .events(events), .levels(levels), .remotes_registered(rem_reg),
    .registered_with_base(reg_base), .heard_system_network_id(h_sys),
    .heard_parent_network_id(h_par), .heard_key(h_key),
    .sleep_request_n(sleep_n), .char_data(char_data),
    .char_valid(char_valid), .char_ready(char_ready),
    .link_carrier_indicator(carrier), .host_rate(host_rate));
  host_terminal host_u (.ref_clk(ref_clk), .rst(rst), .slow(slow),
    .char_data(char_data), .char_valid(char_valid),
    .char_ready(char_ready), .sleep_request_n(sleep_n));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] g, e, input string m);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    check(32'(n), 32'h2, "bus ack");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, 4'hF);
  endtask
  task automatic dwell(input logic [5:0] ch, input logic [7:0] ev);
    @(posedge ref_clk);
    levels.channel <= ch;
    events <= ev;
    dwell_end <= 1'b1;
    @(posedge ref_clk);
    events <= 8'h00;
    dwell_end <= 1'b0;
  endtask
  task automatic wait_chars(input int n);
    int k;
    k = 0;
    while (host_u.got.size() < n && k < 2000) begin
      @(posedge ref_clk);
      k++;
    end
    repeat (40) @(posedge ref_clk);
    check(32'(host_u.got.size()), 32'(n), "char count");
  endtask
  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction
  function automatic logic [23:0] hx3(input logic [11:0] v);
    return {hx(v[11:8]), hx(v[7:4]), hx(v[3:0])};
  endfunction
  task automatic carr(input logic e);
    repeat (3) @(posedge ref_clk);
    check(32'(carrier), 32'(e), "carrier");
  endtask
  task automatic rec_check(input logic [55:0] b);
    logic [23:0] st;
    wait_chars(27);
    st = {host_u.got[0], host_u.got[1], host_u.got[2]};
    check(32'(st == hx3(s0) || st == hx3(s0 + 12'h1)), 1, "stamp");
    check(32'(host_u.got[3]), 32'h3E, "stamp end");
    for (int k = 0; k < 7; k++) begin
      check(32'(host_u.got[4 + 3 * k]), 32'h20, "space");
      check(32'(host_u.got[5 + 3 * k]), hx(b[55 - 8 * k -: 4]), "hi");
      check(32'(host_u.got[6 + 3 * k]), hx(b[51 - 8 * k -: 4]), "lo");
    end
    check({host_u.got[25], host_u.got[26]}, 32'h0D0A, "rec end");
    host_u.got.delete();
  endtask
  initial begin
    rst = 1'b1;
    {cyc, stb, we, adr, sel, wdat, dwell_end} = '0;
    events = '0;
    levels = '0;
    {rem_reg, reg_base, h_key, slow} = {2'b00, 16'h0, 1'b1};
    h_sys = 8'h12;
    h_par = 8'h34;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    check(host_rate, 32'h2580, "host rate");
    for (int k = 0; k < 5; k++) begin
      xfer(addrs[k], 1'b0, 32'h0, 4'hF);
      check(q, rvals[k], "reset value");
    end
    xfer(8'h08, 1'b1, 32'hABCD, 4'h1);
    xfer(8'h08, 1'b0, 32'h0, 4'hF);
    check(q, 32'h00CD, "key lanes");
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h1);
    for (int i = 0; i < 50; i++) dwell(6'(i), 8'h80 | 8'(i % 8));
    wait_chars(52);
    for (int i = 0; i < 50; i++) begin
      check(32'(host_u.got[i]), (i % 8 == 0) ? 32'h2E : 32'(8'h30 + i % 8),
            "log char");
    end
    check({host_u.got[50], host_u.got[51]}, 32'h0D0A, "log end");
    host_u.got.delete();
    slow <= 1'b0;
    wr(8'h00, 32'h2);
    levels.last_packet_strength <= 8'hDA;
    levels.idle_channel_strength <= 8'h98;
    levels.range_delay <= 8'h07;
    {levels.inbound_flow_off, levels.outbound_flow_off} <= 2'b10;
    levels.host_hold <= 1'b1;
    xfer(8'h0C, 1'b0, 32'h0, 4'hF);
    s0 = q[11:0];
    dwell(6'h31, 8'hA5);
    rec_check(56'h31_05_DA_98_07_0A_A5);
    {levels.inbound_flow_off, levels.outbound_flow_off} <= 2'b01;
    levels.host_hold <= 1'b0;
    xfer(8'h0C, 1'b0, 32'h0, 4'hF);
    s0 = q[11:0];
    dwell(6'h00, 8'h58);
    rec_check(56'h00_30_DA_98_07_04_58);
    wr(8'h00, 32'h0);
    dwell(6'h05, 8'h01);
    wait_chars(0);
    wr(8'h00, 32'h4);
    rem_reg <= 1'b1;
    carr(1'b1);
    rem_reg <= 1'b0;
    carr(1'b0);
    wr(8'h00, 32'hC);
    carr(1'b1);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'hFF12);
    reg_base <= 1'b1;
    carr(1'b1);
    xfer(8'h0C, 1'b0, 32'h0, 4'hF);
    check(32'(q[16]), 32'h1, "status carrier");
    h_key <= 16'h0001;
    carr(1'b0);
    h_key <= 16'h0000;
    wr(8'h04, 32'h3412);
    carr(1'b1);
    h_sys <= 8'h13;
    carr(1'b0);
    xfer(8'h0C, 1'b0, 32'h0, 4'hF);
    s0 = q[11:0];
    while (s0 != 12'hCE5 || q[11:0] == s0) begin
      xfer(8'h0C, 1'b0, 32'h0, 4'hF);
      if (q[11:0] !== s0) begin
        check(q[11:0], (s0 == 12'hCE5) ? 32'h0 : 32'(s0 + 12'h1),
              "stamp step");
        if (s0 == 12'hCE5) break;
        s0 = q[11:0];
      end
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
